// ---- src/mdsu_pkg.sv ----
// Purpose: shared constants and types of the multiply/divide/shift unit
// Assumes: one 50 MHz clock; machine cycle emulated by a clock divider
// Notes: register addresses are indices on the byte-wide register port
package mdsu_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  localparam logic [2:0] A_OPR0 = 3'h0;
  localparam logic [2:0] A_OPR1 = 3'h1;
  localparam logic [2:0] A_OPR2 = 3'h2;
  localparam logic [2:0] A_OPR3 = 3'h3;
  localparam logic [2:0] A_OPR4 = 3'h4;
  localparam logic [2:0] A_OPR5 = 3'h5;
  localparam logic [2:0] A_CTRL = 3'h6;
  localparam int NUM_OPR = 6;

  // control register layout
  localparam int CTRL_ERR_BIT = 7;
  localparam int CTRL_OVF_BIT = 6;
  localparam int CTRL_DIR_BIT = 5;
  localparam int CTRL_CNT_LSB = 0;
  localparam int CTRL_CNT_W = 5;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] OPR_RST = 8'h00;

  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int MACHINE_CYCLE_NS = 500;
  localparam int MC_CLKS = (MACHINE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] MC_DIV32 = 3'h6;
  localparam logic [2:0] MC_DIV16 = 3'h4;
  localparam logic [2:0] MC_MUL = 3'h4;
  localparam logic [2:0] MC_SHIFT = 3'h6;
  localparam logic [2:0] SHIFT_PER_MC = 3'h6;

  typedef enum logic [2:0] {
    OP_DIV32,
    OP_DIV16,
    OP_MUL,
    OP_SHIFT,
    OP_NORM
  } mdsu_op_t;

endpackage : mdsu_pkg

// ---- src/mdsu_bus_if.sv ----
// Purpose: byte-wide register port between the host core and the unit
// Assumes: both ends run on the same clock
// Notes: one access per cycle; read data returns one cycle later
`timescale 1ns/1ps
interface mdsu_bus_if;
  logic wr_en;
  logic rd_en;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rvalid;
  logic busy;

  modport dev (
    input wr_en, rd_en, addr, wdata,
    output rdata, rvalid, busy
  );
  modport host (
    output wr_en, rd_en, addr, wdata,
    input rdata, rvalid, busy
  );
endinterface : mdsu_bus_if

// ---- src/mdsu_arith_unit.sv ----
// Purpose: unsigned multiply/divide/shift/normalize unit with six operand
//   bytes and one control byte
// Assumes: the host writes operands in the order that selects the operation
// Notes: one machine cycle is CYC_CLKS clocks; accesses while busy set err
`timescale 1ns/1ps
// Behaviour
// - 32/16 divide, 16x16 multiply, 32-bit shift/normalize
// - all operands and results unsigned
// - results and cycle counts per operation
// - one execution cycle equals one machine cycle
// - shift at most six bits per cycle
// - six operand bytes plus one control byte
// - load, compute, then read back
// - write order selects the operation
// - control write after four bytes starts shift
// - divide operands written low first, byte 5 last
// - multiply writes bytes 0, 4, 1, 5
// - quotient in bytes 0-3 (bytes 0-1 for the 16-bit divide), remainder in 4-5
// - product in bytes 0-3, low first
// - shift value in and out of bytes 0-3
module mdsu_arith_unit
  import mdsu_pkg::*;
#(
  parameter int CYC_CLKS = MC_CLKS
) (
  input wire logic clk,
  input wire logic srst,
  mdsu_bus_if.dev bus
);

  localparam int TW = (CYC_CLKS > 1) ? $clog2(CYC_CLKS) : 1;

  if (CYC_CLKS < 2) begin : g_bad_cyc
    $error("mdsu_arith_unit: CYC_CLKS must be at least 2");
  end

  typedef enum logic [3:0] {
    SQ_NONE,
    SQ_0,
    SQ_01,
    SQ_012,
    SQ_0123,
    SQ_01234,
    SQ_014,
    SQ_04,
    SQ_041
  } mdsu_seq_t;

  // leading zeros of v, capped at one machine cycle's worth of shifts
  function automatic logic [2:0] mdsu_lz6(input logic [31:0] v);
    logic [2:0] n;
    n = SHIFT_PER_MC;
    for (int i = 5; i >= 0; i--) begin
      if (v[31 - i]) begin
        n = 3'(i);
      end
    end
    return n;
  endfunction : mdsu_lz6

  logic [7:0] opr [0:NUM_OPR-1];
  mdsu_seq_t seq;
  mdsu_seq_t next_seq;
  mdsu_op_t op;
  logic busy;
  logic [TW-1:0] tick_cnt;
  logic [2:0] mc_left;
  logic [4:0] shift_left;
  logic err_flag;
  logic ovf_flag;
  logic dir_right;
  logic [4:0] shift_cnt;
  logic [7:0] rdata;
  logic rvalid;

  assign bus.rdata = rdata;
  assign bus.rvalid = rvalid;
  assign bus.busy = busy;

  // operand views
  wire [31:0] a32 = {opr[3], opr[2], opr[1], opr[0]};
  wire [15:0] a16 = a32[15:0];
  wire [15:0] b16 = {opr[5], opr[4]};
  wire div_zero = (b16 == 16'h0000);
  wire [15:0] b_safe = div_zero ? 16'h0001 : b16;

  // unsigned arithmetic only
  wire [31:0] q32 = div_zero ? 32'hffffffff : a32 / {16'h0000, b_safe};
  wire [31:0] r32w = a32 % {16'h0000, b_safe};
  wire [15:0] q16 = div_zero ? 16'hffff : a16 / b_safe;
  wire [15:0] r16 = a16 % b_safe;
  wire [31:0] prod = a16 * b16;

  // shift and normalize step, up to six positions per machine cycle
  wire [2:0] lz = mdsu_lz6(a32);
  wire [2:0] sh_step = (shift_left > 5'(SHIFT_PER_MC)) ? SHIFT_PER_MC : shift_left[2:0];
  wire [2:0] step_amt = (op == OP_NORM) ? lz : sh_step;
  wire [31:0] stepped = (dir_right && op == OP_SHIFT) ? (a32 >> step_amt)
                                                      : (a32 << step_amt);
  wire norm_done = (a32 == 32'h00000000) || (lz < SHIFT_PER_MC);
  wire shift_done = (shift_left <= 5'(SHIFT_PER_MC));
  wire is_shop = (op == OP_SHIFT) || (op == OP_NORM);
  wire step_done = (op == OP_NORM) ? norm_done : shift_done;

  // machine-cycle timing
  wire tick = busy && (tick_cnt == TW'(CYC_CLKS - 1));
  wire fin = tick && ((mc_left == 3'h1) || (is_shop && step_done));

  // bus decode
  wire wr_idle = bus.wr_en && !busy;
  wire w5 = wr_idle && (bus.addr == A_OPR5);
  wire wc = wr_idle && (bus.addr == A_CTRL);
  wire access_busy = busy && (bus.wr_en || bus.rd_en);
  wire ctrl_read = bus.rd_en && (bus.addr == A_CTRL);
  wire [4:0] wr_cnt = bus.wdata[CTRL_CNT_LSB +: CTRL_CNT_W];

  // operation chosen by the write order, last write starts it
  wire start_div32 = w5 && (seq == SQ_01234);
  wire start_div16 = w5 && (seq == SQ_014);
  wire start_mul = w5 && (seq == SQ_041);
  wire start_sh = wc && (seq == SQ_0123);
  wire start = start_div32 || start_div16 || start_mul || start_sh;
  wire start_norm = start_sh && (wr_cnt == 5'h00);

  wire mdsu_op_t start_op = start_div32 ? OP_DIV32 :
                            start_div16 ? OP_DIV16 :
                            start_mul ? OP_MUL :
                            start_norm ? OP_NORM : OP_SHIFT;
  // execution times per operation
  wire [2:0] start_mc = start_div32 ? MC_DIV32 :
                        start_div16 ? MC_DIV16 :
                        start_mul ? MC_MUL : MC_SHIFT;

  // result placement
  wire [31:0] res32 = (op == OP_DIV32) ? q32 :
                      (op == OP_DIV16) ? {a32[31:16], q16} :
                      (op == OP_MUL) ? prod : stepped;
  wire [15:0] res_rem = (op == OP_DIV32) ? r32w[15:0] : r16;
  wire load32 = (fin && !is_shop) || (tick && is_shop);
  wire load_rem = fin && (op == OP_DIV32 || op == OP_DIV16);

  wire ovf_res = ((op == OP_DIV32 || op == OP_DIV16) && div_zero) ||
                 ((op == OP_MUL) && (prod[31:16] != 16'h0000)) ||
                 ((op == OP_NORM) && (a32 == 32'h00000000));

  wire [7:0] ctrl_byte = {err_flag, ovf_flag, dir_right, shift_cnt};
  wire [7:0] rd_byte = (bus.addr < A_CTRL) ? opr[bus.addr] :
                       (bus.addr == A_CTRL) ? ctrl_byte : 8'h00;

  // write-order tracker
  always_comb begin
    next_seq = seq;
    if (wr_idle) begin
      case (bus.addr)
        A_OPR0: next_seq = SQ_0;
        A_OPR1: next_seq = (seq == SQ_0) ? SQ_01 :
                           (seq == SQ_04) ? SQ_041 : SQ_NONE;
        A_OPR2: next_seq = (seq == SQ_01) ? SQ_012 : SQ_NONE;
        A_OPR3: next_seq = (seq == SQ_012) ? SQ_0123 : SQ_NONE;
        A_OPR4: next_seq = (seq == SQ_0123) ? SQ_01234 :
                           (seq == SQ_01) ? SQ_014 :
                           (seq == SQ_0) ? SQ_04 : SQ_NONE;
        default: next_seq = SQ_NONE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      seq <= SQ_NONE;
    end else begin
      seq <= next_seq;
    end
  end

  // compute phase sequencing
  always_ff @(posedge clk) begin
    if (srst) begin
      busy <= 1'b0;
      tick_cnt <= '0;
      mc_left <= 3'h0;
      op <= OP_DIV32;
    end else if (start) begin
      busy <= 1'b1;
      tick_cnt <= '0;
      mc_left <= start_mc;
      op <= start_op;
    end else if (busy) begin
      busy <= !fin;
      tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
      mc_left <= tick ? mc_left - 3'h1 : mc_left;
    end
  end

  // six operand/result bytes
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < NUM_OPR; i++) begin
        opr[i] <= OPR_RST;
      end
    end else begin
      for (int i = 0; i < NUM_OPR; i++) begin
        if (wr_idle && bus.addr == 3'(i)) begin
          opr[i] <= bus.wdata;
        end
      end
      if (load32) begin
        for (int i = 0; i < 4; i++) begin
          opr[i] <= res32[8*i +: 8];
        end
      end
      if (load_rem) begin
        opr[4] <= res_rem[7:0];
        opr[5] <= res_rem[15:8];
      end
    end
  end

  // control byte: direction and count steer the shift
  always_ff @(posedge clk) begin
    if (srst) begin
      {err_flag, ovf_flag, dir_right, shift_cnt} <= CTRL_RST;
      shift_left <= 5'h00;
    end else begin
      // a busy access in the same cycle as the clearing read wins
      err_flag <= access_busy || (err_flag && !ctrl_read);
      if (wc) begin
        dir_right <= bus.wdata[CTRL_DIR_BIT];
        shift_cnt <= wr_cnt;
        shift_left <= wr_cnt;
      end else if (tick && op == OP_NORM) begin
        shift_cnt <= shift_cnt + 5'(step_amt);
      end else if (tick && op == OP_SHIFT) begin
        shift_left <= shift_left - 5'(sh_step);
      end
      if (start) begin
        ovf_flag <= 1'b0;
      end else if (fin) begin
        ovf_flag <= ovf_res;
      end
    end
  end

  // read-back path, one cycle latency
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= bus.rd_en;
      if (bus.rd_en) begin
        rdata <= rd_byte;
      end
    end
  end

endmodule : mdsu_arith_unit

// ---- src/mdsu_host.sv ----
// Purpose: host-side sequencer that drives the arithmetic unit
// Assumes: unit on the same clock, reached through mdsu_bus_if
// Notes: waits the fixed execution time instead of polling busy
`timescale 1ns/1ps
module mdsu_host
  import mdsu_pkg::*;
#(
  parameter int CYC_CLKS = MC_CLKS
) (
  input wire logic clk,
  input wire logic srst,
  mdsu_bus_if.host bus,
  input wire logic cmd_valid,
  input wire mdsu_op_t cmd_op,
  input wire logic [31:0] cmd_a,
  input wire logic [15:0] cmd_b,
  input wire logic cmd_right,
  input wire logic [4:0] cmd_count,
  output logic cmd_ready,
  output logic res_valid,
  output logic [31:0] res_value,
  output logic [15:0] res_rem,
  output logic [7:0] res_ctrl
);

  if (CYC_CLKS < 2 || CYC_CLKS > 8000) begin : g_bad_cyc
    $error("mdsu_host: CYC_CLKS out of range");
  end

  typedef enum logic [2:0] {
    H_IDLE,
    H_WR,
    H_WAIT,
    H_RD,
    H_RWAIT,
    H_DONE
  } mdsu_hst_t;

  // write order per operation
  function automatic logic [2:0] mdsu_wr_addr(mdsu_op_t o, logic [2:0] i);
    case (o)
      OP_DIV32: return i;
      OP_DIV16: return (i < 3'h2) ? i : (i == 3'h2) ? A_OPR4 : A_OPR5;
      OP_MUL: return (i == 3'h0) ? A_OPR0 : (i == 3'h1) ? A_OPR4 :
                     (i == 3'h2) ? A_OPR1 : A_OPR5;
      default: return (i < 3'h4) ? i : A_CTRL;
    endcase
  endfunction : mdsu_wr_addr

  // read order, control byte last for the flags
  function automatic logic [2:0] mdsu_rd_addr(mdsu_op_t o, logic [2:0] i);
    case (o)
      OP_DIV32: return (i < 3'h6) ? i : A_CTRL;
      OP_DIV16: return (i < 3'h2) ? i : (i < 3'h4) ? i + 3'h2 : A_CTRL;
      default: return (i < 3'h4) ? i : A_CTRL;
    endcase
  endfunction : mdsu_rd_addr

  mdsu_hst_t st;
  mdsu_op_t op;
  logic [31:0] a;
  logic [15:0] b;
  logic right;
  logic [4:0] cnt;
  logic [2:0] idx;
  logic [15:0] wait_cnt;
  logic wr_en;
  logic rd_en;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic [2:0] rd_sel;

  assign bus.wr_en = wr_en;
  assign bus.rd_en = rd_en;
  assign bus.addr = addr;
  assign bus.wdata = wdata;

  wire [2:0] last_wr = (op == OP_DIV32) ? 3'h5 : (op == OP_SHIFT || op == OP_NORM) ?
                       3'h4 : 3'h3;
  wire [2:0] last_rd = (op == OP_DIV32) ? 3'h6 : 3'h4;
  wire [2:0] wa = mdsu_wr_addr(op, idx);
  wire [7:0] ctrl_wr = {2'b00, right, (op == OP_NORM) ? 5'h00 : cnt};
  wire [7:0] wbyte = (wa < A_OPR4) ? a[8*wa +: 8] :
                     (wa == A_OPR4) ? b[7:0] :
                     (wa == A_OPR5) ? b[15:8] : ctrl_wr;
  wire [2:0] exec_mc = (op == OP_DIV32) ? MC_DIV32 : (op == OP_DIV16) ? MC_DIV16 :
                       (op == OP_MUL) ? MC_MUL : MC_SHIFT;
  // wait the full execution time before reading
  wire [15:0] wait_init = 16'(exec_mc * CYC_CLKS + 1);

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= H_IDLE;
      op <= OP_DIV32;
      a <= 32'h00000000;
      b <= 16'h0000;
      right <= 1'b0;
      cnt <= 5'h00;
      idx <= 3'h0;
      wait_cnt <= 16'h0000;
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      addr <= 3'h0;
      wdata <= 8'h00;
      rd_sel <= 3'h0;
      cmd_ready <= 1'b0;
      res_valid <= 1'b0;
      res_value <= 32'h00000000;
      res_rem <= 16'h0000;
      res_ctrl <= 8'h00;
    end else begin
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      res_valid <= 1'b0;
      case (st)
        H_IDLE: begin
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            op <= cmd_op;
            a <= cmd_a;
            b <= cmd_b;
            right <= cmd_right;
            cnt <= cmd_count;
            idx <= 3'h0;
            st <= H_WR;
          end
        end
        H_WR: begin
          wr_en <= 1'b1;
          addr <= wa;
          wdata <= wbyte;
          idx <= idx + 3'h1;
          if (idx == last_wr) begin
            wait_cnt <= wait_init;
            st <= H_WAIT;
          end
        end
        H_WAIT: begin
          wait_cnt <= wait_cnt - 16'h0001;
          if (wait_cnt == 16'h0000) begin
            idx <= 3'h0;
            st <= H_RD;
          end
        end
        H_RD: begin
          rd_en <= 1'b1;
          addr <= mdsu_rd_addr(op, idx);
          rd_sel <= mdsu_rd_addr(op, idx);
          st <= H_RWAIT;
        end
        H_RWAIT: begin
          if (bus.rvalid) begin
            if (rd_sel < A_OPR4) begin
              res_value[8*rd_sel +: 8] <= bus.rdata;
            end else if (rd_sel == A_OPR4) begin
              res_rem[7:0] <= bus.rdata;
            end else if (rd_sel == A_OPR5) begin
              res_rem[15:8] <= bus.rdata;
            end else begin
              res_ctrl <= bus.rdata;
            end
            idx <= idx + 3'h1;
            st <= (idx == last_rd) ? H_DONE : H_RD;
          end
        end
        H_DONE: begin
          res_valid <= 1'b1;
          st <= H_IDLE;
        end
        default: st <= H_IDLE;
      endcase
    end
  end

endmodule : mdsu_host

// ---- tb/mdsu_chk.sv ----
// Purpose: timing checks on the register port between host and unit
// Assumes: one clock, srst synchronous active high
// Notes: the last three write addresses tell which write starts work
`timescale 1ns/1ps
module mdsu_chk #(
  parameter int CYC_CLKS = 2
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic busy
);
  logic [8:0] hist;
  int busy_cnt;
  int exp_len;
  wire mul_seq = hist == {3'h0, 3'h4, 3'h1};
  wire d16_seq = hist == {3'h0, 3'h1, 3'h4};
  wire d32_seq = hist == {3'h2, 3'h3, 3'h4};
  wire sh_seq = hist == {3'h1, 3'h2, 3'h3};
  wire wr_ok = wr_en && !busy;
  wire start_md = wr_ok && addr == 3'h5 && (mul_seq || d16_seq || d32_seq);
  wire start_sh = wr_ok && addr == 3'h6 && sh_seq;
  wire start = start_md || start_sh;
  // zero marks a shift or normalize, whose length depends on the count or the operand
  wire [31:0] next_len = d32_seq ? 6 * CYC_CLKS : (start_md ? 4 * CYC_CLKS : 0);

  always_ff @(posedge clk) begin
    if (srst) begin
      hist <= 9'h000;
      busy_cnt <= 0;
      exp_len <= 0;
    end else begin
      if (wr_ok) hist <= {hist[5:0], addr};
      if (start) busy_cnt <= 0;
      else if (busy) busy_cnt <= busy_cnt + 1;
      if (start) exp_len <= int'(next_len);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_read_answered: assert property (rd_en |=> rvalid)
    else $error("rvalid missing after read");
  a_rvalid_only_read: assert property (!rd_en |=> !rvalid)
    else $error("rvalid without read");
  a_rdata_holds: assert property (!rd_en |=> $stable(rdata))
    else $error("rdata moved without read");
  a_single_access: assert property (!(wr_en && rd_en))
    else $error("read and write together");
  a_quiet_while_busy: assert property (busy |-> !wr_en && !rd_en)
    else $error("access while busy");
  a_busy_on_start: assert property (start |=> busy)
    else $error("start write did not raise busy");
  a_busy_has_cause: assert property ($rose(busy) |-> $past(start))
    else $error("busy rose without start write");
  a_fixed_time: assert property ($fell(busy) && exp_len != 0 |-> busy_cnt == exp_len)
    else $error("divide or multiply time wrong");
  a_shift_time: assert property ($fell(busy) && exp_len == 0 |->
    busy_cnt > 0 && busy_cnt <= 6 * CYC_CLKS)
    else $error("shift time out of range");

  c_mul: cover property (start_md && mul_seq);
  c_div32: cover property (start_md && d32_seq);
  c_shift: cover property (start_sh);
  c_done: cover property ($fell(busy));
endmodule : mdsu_chk

// ---- tb/mul_div_shift_unit_bench.sv ----
// Purpose: host and unit joined, commands driven, results judged
// Assumes: CYC_CLKS shortened to 2 on both ends
// Notes: expected values come from plain unsigned arithmetic here
`timescale 1ns/1ps
module mul_div_shift_unit_bench
  import mdsu_pkg::*;
;
  localparam int CYC = 2;
  logic clk;
  logic srst;
  logic cmd_valid;
  mdsu_op_t cmd_op;
  logic [31:0] cmd_a;
  logic [15:0] cmd_b;
  logic cmd_right;
  logic [4:0] cmd_count;
  logic cmd_ready;
  logic res_valid;
  logic [31:0] res_value;
  logic [15:0] res_rem;
  logic [7:0] res_ctrl;
  int n_fail;
  int samples_checked;

  mdsu_bus_if i_mdsu_bus_if ();
  mdsu_arith_unit #(.CYC_CLKS(CYC)) i_mdsu_arith_unit (
    .clk(clk), .srst(srst), .bus(i_mdsu_bus_if.dev));
  mdsu_host #(.CYC_CLKS(CYC)) i_mdsu_host (
    .clk(clk), .srst(srst), .bus(i_mdsu_bus_if.host), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_a(cmd_a), .cmd_b(cmd_b), .cmd_right(cmd_right),
    .cmd_count(cmd_count), .cmd_ready(cmd_ready), .res_valid(res_valid),
    .res_value(res_value), .res_rem(res_rem), .res_ctrl(res_ctrl));
  mdsu_chk #(.CYC_CLKS(CYC)) i_mdsu_chk (
    .clk(clk), .srst(srst), .wr_en(i_mdsu_bus_if.wr_en), .rd_en(i_mdsu_bus_if.rd_en),
    .addr(i_mdsu_bus_if.addr), .wdata(i_mdsu_bus_if.wdata),
    .rdata(i_mdsu_bus_if.rdata), .rvalid(i_mdsu_bus_if.rvalid),
    .busy(i_mdsu_bus_if.busy));

  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_val

  task automatic chk_ctrl(input logic [7:0] exp);
    samples_checked++;
    if (res_ctrl !== exp) begin
      n_fail++;
      $display("unexpected ctrl expected %h seen %h", exp, res_ctrl);
    end
  endtask : chk_ctrl

  // one command, driven at falling edges; returns at the first falling clock edge with res_valid high
  task automatic run_cmd(input mdsu_op_t op, input logic [31:0] a, input logic [15:0] b,
                         input logic right, input logic [4:0] count);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 600) begin
      @(negedge clk);
      n++;
    end
    cmd_op = op;
    cmd_a = a;
    cmd_b = b;
    cmd_right = right;
    cmd_count = count;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    chk_val("cmd_ready", 32'h00000000, {31'h00000000, cmd_ready});
    while (res_valid !== 1'b1 && n < 600) begin
      @(negedge clk);
      n++;
    end
    if (n >= 600) begin
      n_fail++;
      $display("unexpected hang expected res_valid seen none");
      report_and_stop();
    end
  endtask : run_cmd

  task automatic t_mul();
    run_cmd(OP_MUL, 32'h0000ffff, 16'hffff, 1'b0, 5'h00);
    chk_val("product", 32'hfffe0001, res_value);
    chk_ctrl(8'h40);
    run_cmd(OP_MUL, 32'hffff0003, 16'h0005, 1'b0, 5'h00);
    chk_val("product", 32'h0000000f, res_value);
    chk_ctrl(8'h00);
    $display("test mul done");
  endtask : t_mul

  task automatic t_div32(input logic [31:0] a, input logic [15:0] b);
    run_cmd(OP_DIV32, a, b, 1'b0, 5'h00);
    chk_val("quotient", a / {16'h0000, b}, res_value);
    chk_val("remainder", a % {16'h0000, b}, {16'h0000, res_rem});
    $display("test div32 done");
  endtask : t_div32

  task automatic t_div16();
    run_cmd(OP_DIV16, 32'h0000ffff, 16'h0007, 1'b0, 5'h00);
    chk_val("quotient16", 32'h00002492, {16'h0000, res_value[15:0]});
    chk_val("remainder16", 32'h00000001, {16'h0000, res_rem});
    run_cmd(OP_DIV16, 32'h00001234, 16'h0000, 1'b0, 5'h00);
    chk_val("quotient16", 32'h0000ffff, {16'h0000, res_value[15:0]});
    chk_ctrl(8'h40);
    $display("test div16 done");
  endtask : t_div16

  task automatic t_shift();
    run_cmd(OP_SHIFT, 32'h80000001, 16'h0000, 1'b0, 5'h05);
    chk_val("shifted", 32'h00000020, res_value);
    chk_ctrl(8'h05);
    run_cmd(OP_SHIFT, 32'h80000000, 16'h0000, 1'b1, 5'h1f);
    chk_val("shifted", 32'h00000001, res_value);
    chk_ctrl(8'h3f);
    run_cmd(OP_NORM, 32'h00001000, 16'h0000, 1'b0, 5'h00);
    chk_val("normalized", 32'h80000000, res_value);
    chk_ctrl(8'h13);
    $display("test shift done");
  endtask : t_shift

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    srst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = OP_MUL;
    cmd_a = 32'h00000000;
    cmd_b = 16'h0000;
    cmd_right = 1'b0;
    cmd_count = 5'h00;
    n_fail = 0;
    samples_checked = 0;
    repeat (6) @(negedge clk);
    srst = 1'b0;
    t_mul();
    t_div32(32'h12345678, 16'h1234);
    t_div32(32'hfffffffe, 16'hffff);
    t_div16();
    t_shift();
    report_and_stop();
  end
endmodule : mul_div_shift_unit_bench
